/* File: src/bridge_chopper.v */
// Fixed off-time PWM chopper for one full bridge
// Assumes the trip input is synchronous; counts come from the top
`timescale 1ns/100ps
module bridge_chopper #(
  parameter CW = 16
) (
  clock,
  resetn,
  run,
  mixed,
  trip,
  off_cycles,
  fast_cycles,
  blank_cycles,
  source_on,
  sink_on,
  fast_decay
);
  input  wire          clock;
  input  wire          resetn;
  input  wire          run;
  input  wire          mixed;
  input  wire          trip;
  input  wire [CW-1:0] off_cycles;
  input  wire [CW-1:0] fast_cycles;
  input  wire [CW-1:0] blank_cycles;
  output reg           source_on;
  output reg           sink_on;
  output reg           fast_decay;

  reg [CW-1:0] off_count;
  reg [CW-1:0] blank_count;
  reg          in_off;
  reg          mixed_cycle;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      off_count   <= {CW{1'b0}};
      blank_count <= {CW{1'b0}};
      in_off      <= 1'b0;
      mixed_cycle <= 1'b1;
      source_on   <= 1'b0;
      sink_on     <= 1'b0;
      fast_decay  <= 1'b0;
    end else if (!run) begin
      off_count   <= {CW{1'b0}};
      blank_count <= blank_cycles;
      in_off      <= 1'b0;
      source_on   <= 1'b0;
      sink_on     <= 1'b0;
      fast_decay  <= 1'b0;
    end else if (!in_off) begin
      source_on  <= 1'b1;
      sink_on    <= 1'b1;
      fast_decay <= 1'b0;
      if (blank_count != {CW{1'b0}}) begin
        blank_count <= blank_count - {{(CW-1){1'b0}}, 1'b1};
      end else if (trip) begin
        in_off      <= 1'b1;
        mixed_cycle <= mixed;
        off_count   <= off_cycles;
        blank_count <= blank_cycles;
        source_on   <= 1'b0;
        sink_on     <= ~mixed;
        fast_decay  <= mixed;
      end
    end else begin
      if (blank_count != {CW{1'b0}}) begin
        blank_count <= blank_count - {{(CW-1){1'b0}}, 1'b1};
      end
      if (off_count <= {{(CW-1){1'b0}}, 1'b1}) begin
        in_off      <= 1'b0;
        blank_count <= blank_cycles;
        source_on   <= 1'b1;
        sink_on     <= 1'b1;
        fast_decay  <= 1'b0;
      end else begin
        off_count <= off_count - {{(CW-1){1'b0}}, 1'b1};
        if (mixed_cycle && (off_cycles - off_count) >= fast_cycles) begin
          fast_decay <= 1'b0;
          sink_on    <= 1'b1;
        end
      end
    end
  end
endmodule // bridge_chopper

/* File: src/microstep_translator_chopper.v */
// Step/direction translator with two fixed off-time bridge choppers
// Assumes Avalon-MM master on the same clock; trips and faults synchronous
//
// Function
// - Reset loads Home levels and polarities, both bridges mixed decay.
// - Each advance rising edge moves translator one increment.
// - Translator drives levels and polarities, increment set by resolution.
// - Falling level picks mixed decay, equal or higher picks slow.
// - Resolution change applies only at next advance rising edge.
// - Direction picks walk sense, applied at next advance rising edge.
// - Mixed decay: fast for first 31.25% of off time, then slow.
// - Setting high: 30 us off time, automatic decay, full step slow.
// - Setting low: 30 us off time, mixed decay always.
// - Resistor setting: off time resistance/825 us, automatic decay.
// - Reset held: Home, FETs off, advance pulses ignored.
// - On phase enables diagonal pair; trip clears latch per decay mode.
// - One-shot holds source FET off for off interval, then on again.
// - Comparator blanked about 1 us after each switching event.
// - Thermal or overcurrent reset returns translator Home.
// - Selects: LL full, HL half, LH quarter, HH eighth.
// - Home is 45 degrees; sequence defined for direction high.
`timescale 1ns/100ps
`include "stepper_regs.vh"
module microstep_translator_chopper #(
  parameter CLOCK_MHZ = `CLOCK_MHZ,
  parameter CW        = 20
) (
  clock,
  resetn,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  level1,
  level2,
  polarity1,
  polarity2,
  mixed1,
  mixed2,
  source1,
  sink1,
  fast1,
  source2,
  sink2,
  fast2
);
  input  wire        clock;
  input  wire        resetn;
  input  wire [3:0]  avs_address;
  input  wire        avs_read;
  input  wire        avs_write;
  input  wire [31:0] avs_writedata;
  output reg  [31:0] avs_readdata;
  output reg         avs_waitrequest;
  output reg  [6:0]  level1;
  output reg  [6:0]  level2;
  output reg         polarity1;
  output reg         polarity2;
  output reg         mixed1;
  output reg         mixed2;
  output wire        source1;
  output wire        sink1;
  output wire        fast1;
  output wire        source2;
  output wire        sink2;
  output wire        fast2;

  localparam [CW-1:0] FIXED_OFF = (`FIXED_OFF_US * CLOCK_MHZ);
  localparam [CW-1:0] BLANK     = (`BLANK_US * CLOCK_MHZ);
  localparam [2:0]    FAST_MUL  = `FAST_NUM;

  localparam ST_IDLE  = 2'h0;
  localparam ST_READ  = 2'h1;
  localparam ST_LOAD1 = 2'h2;
  localparam ST_LOAD2 = 2'h3;

  reg  [31:0]   control;
  reg  [31:0]   offtime;
  reg  [4:0]    sync_a;
  reg  [4:0]    sync_b;
  reg           step_prev;
  reg  [4:0]    position;
  reg  [1:0]    state;
  reg  [4:0]    pending_pos;
  reg  [3:0]    table_index;
  reg  [CW-1:0] off_cycles;
  reg  [CW-1:0] fast_cycles;
  reg  [4:0]    next_position;
  reg  [4:0]    increment;
  reg  [4:0]    ph2_pos;
  wire [6:0]    table_level;
  wire          run;
  wire          full_step;
  wire          force_mixed;
  wire [31:0]   offtime_us;
  wire [CW+2:0] fast_scaled;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {control[`CTL_RESETN_BIT], control[`CTL_MS_HI_BIT],
                 control[`CTL_MS_LO_BIT], control[`CTL_DIR_BIT], control[`CTL_STEP_BIT]};
      sync_b <= sync_a;
    end
  end

  assign run = sync_b[4] & ~control[`CTL_FAULT_BIT];
  assign full_step = (sync_b[3:2] == 2'h0);
  assign force_mixed = (offtime[1:0] == `OFFMODE_LOW);
  assign offtime_us = {2'h0, offtime[31:2]} / `RES_DIV;
  // Fast part is 5/16 of the off interval
  assign fast_scaled = off_cycles * FAST_MUL;

  always @* begin
    case (sync_b[3:2])
      2'h0:    increment = 5'h04;
      2'h1:    increment = 5'h02;
      2'h2:    increment = 5'h01;
      default: increment = 5'h01;
    endcase
    if (sync_b[3:2] == 2'h3) begin
      increment = 5'h01;
    end else if (sync_b[3:2] == 2'h2) begin
      increment = 5'h02;
    end else if (sync_b[3:2] == 2'h1) begin
      increment = 5'h04;
    end else begin
      increment = 5'h08;
    end
    if (sync_b[1]) begin
      next_position = position + increment;
    end else begin
      next_position = position - increment;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      off_cycles  <= {CW{1'b0}};
      fast_cycles <= {CW{1'b0}};
    end else begin
      if (offtime[1:0] == `OFFMODE_RES) begin
        off_cycles <= offtime_us[CW-1:0] * CLOCK_MHZ[CW-1:0];
      end else begin
        off_cycles <= FIXED_OFF;
      end
      fast_cycles <= {1'b0, fast_scaled[CW+2:4]};
    end
  end

  // Phase 2 leads phase 1 by 90 degrees
  always @* begin
    ph2_pos = pending_pos + 5'h08;
    if (state == ST_LOAD1) begin
      table_index = (pending_pos[3]) ? (4'h8 - {1'b0, pending_pos[2:0]})
                                     : {1'b0, pending_pos[2:0]};
    end else begin
      table_index = (ph2_pos[3]) ? (4'h8 - {1'b0, ph2_pos[2:0]})
                                 : {1'b0, ph2_pos[2:0]};
    end
  end

  sine_table u_table (
    .clock  (clock),
    .resetn (resetn),
    .index  (table_index),
    .level  (table_level)
  );

  // Translator sequencer
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      position    <= `HOME_INDEX;
      pending_pos <= `HOME_INDEX;
      state       <= ST_IDLE;
      step_prev   <= 1'b0;
      level1      <= 7'h46;
      level2      <= 7'h46;
      polarity1   <= 1'b1;
      polarity2   <= 1'b1;
      mixed1      <= 1'b1;
      mixed2      <= 1'b1;
    end else begin
      step_prev <= sync_b[0];
      if (!run) begin
        position    <= `HOME_INDEX;
        pending_pos <= `HOME_INDEX;
        state       <= ST_LOAD1;
        level1      <= 7'h46;
        polarity1   <= 1'b1;
        mixed1      <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            if (sync_b[0] && !step_prev) begin
              pending_pos <= next_position;
              position    <= next_position;
              state       <= ST_READ;
            end
          end
          ST_READ: begin
            state <= ST_LOAD1;
          end
          ST_LOAD1: begin
            state <= ST_LOAD2;
          end
          ST_LOAD2: begin
            state <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
      // Table output is one cycle behind its index
      if (run && state == ST_LOAD2) begin
        level1    <= table_level;
        polarity1 <= ~pending_pos[4];
        mixed1    <= force_mixed | (run & ~full_step & (table_level < level1))
                     | ~run;
      end
    end
  end

  // Phase 2 loaded one cycle after phase 1 from the shared table
  reg       load2_d;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      load2_d <= 1'b0;
    end else begin
      load2_d <= (state == ST_LOAD2) && run;
    end
  end

  // Phase 2 register update
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      level2    <= 7'h46;
      polarity2 <= 1'b1;
      mixed2    <= 1'b1;
    end else if (!run) begin
      level2    <= 7'h46;
      polarity2 <= 1'b1;
      mixed2    <= 1'b1;
    end else if (load2_d == 1'b0 && state == ST_IDLE) begin
      level2 <= level2;
    end else if (state == ST_IDLE && load2_d) begin
      level2    <= table_level;
      polarity2 <= ~ph2_pos[4];
      mixed2    <= force_mixed | (~full_step & (table_level < level2));
    end
  end

  bridge_chopper #(.CW(CW)) u_bridge1 (
    .clock        (clock),
    .resetn       (resetn),
    .run          (run),
    .mixed        (mixed1),
    .trip         (control[`CTL_TRIP1_BIT]),
    .off_cycles   (off_cycles),
    .fast_cycles  (fast_cycles),
    .blank_cycles (BLANK),
    .source_on    (source1),
    .sink_on      (sink1),
    .fast_decay   (fast1)
  );

  bridge_chopper #(.CW(CW)) u_bridge2 (
    .clock        (clock),
    .resetn       (resetn),
    .run          (run),
    .mixed        (mixed2),
    .trip         (control[`CTL_TRIP2_BIT]),
    .off_cycles   (off_cycles),
    .fast_cycles  (fast_cycles),
    .blank_cycles (BLANK),
    .source_on    (source2),
    .sink_on      (sink2),
    .fast_decay   (fast2)
  );

  // Avalon-MM slave, one wait cycle per access
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control         <= `CTL_RESET;
      offtime         <= `OFFTIME_RESET;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        if (avs_write) begin
          case (avs_address)
            `ADDR_CONTROL: control <= avs_writedata;
            `ADDR_OFFTIME: offtime <= avs_writedata;
            default:       control <= control;
          endcase
        end else begin
          case (avs_address)
            `ADDR_CONTROL:  avs_readdata <= control;
            `ADDR_OFFTIME:  avs_readdata <= offtime;
            `ADDR_STATUS:   avs_readdata <= {16'h0000, mixed2, mixed1, polarity2,
                                             polarity1, fast2, fast1, sink2, sink1,
                                             source2, source1, 4'h0, run, 1'b0};
            `ADDR_POSITION: avs_readdata <= {level2, level1, 13'h0000, position};
            default:        avs_readdata <= 32'h0000_0000;
          endcase
        end
      end
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end
    end
  end
endmodule // microstep_translator_chopper

/* File: src/sine_table.v */
// Microstep current level table, eighth-step resolution, one quarter wave
// Assumes index 0..8 spans 0 to 90 electrical degrees
`timescale 1ns/100ps
module sine_table (
  clock,
  resetn,
  index,
  level
);
  input  wire       clock;
  input  wire       resetn;
  input  wire [3:0] index;
  output reg  [6:0] level;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      level <= 7'h00;
    end else begin
      case (index)
        4'h0:    level <= 7'h00;
        4'h1:    level <= 7'h14;
        4'h2:    level <= 7'h26;
        4'h3:    level <= 7'h38;
        4'h4:    level <= 7'h46;
        4'h5:    level <= 7'h53;
        4'h6:    level <= 7'h5C;
        4'h7:    level <= 7'h62;
        default: level <= 7'h64;
      endcase
    end
  end
endmodule // sine_table

/* File: src/stepper_regs.vh */
// Constants for the microstep translator and chopper
// Assumes a 200 MHz core clock
`ifndef STEPPER_REGS_VH
`define STEPPER_REGS_VH
`define CLOCK_MHZ            200
`define FIXED_OFF_US         30
`define FIXED_OFF_CYCLES     (`FIXED_OFF_US * `CLOCK_MHZ)
`define BLANK_US             1
`define BLANK_CYCLES         (`BLANK_US * `CLOCK_MHZ)
`define FAST_NUM             5
`define FAST_DEN             16
`define RES_DIV              825
`define SINE_STEPS           32
// Register map, byte addresses
`define ADDR_CONTROL         4'h0
`define ADDR_OFFTIME         4'h4
`define ADDR_STATUS          4'h8
`define ADDR_POSITION        4'hC
// Control field positions
`define CTL_STEP_BIT         0
`define CTL_DIR_BIT          1
`define CTL_MS_LO_BIT        2
`define CTL_MS_HI_BIT        3
`define CTL_RESETN_BIT       4
`define CTL_TRIP1_BIT        5
`define CTL_TRIP2_BIT        6
`define CTL_FAULT_BIT        7
`define CTL_RESET            32'h0000_0010
// Off-time mode encodings
`define OFFMODE_HIGH         2'h0
`define OFFMODE_LOW          2'h1
`define OFFMODE_RES          2'h2
`define OFFTIME_RESET        32'h0000_0000
// Position of home in the 1/8 step table
`define HOME_INDEX           5'h04
`endif

/* File: test/avalon_host.sv */
// Host model issuing Avalon-MM register accesses
// Assumes a slave that answers through waitrequest
`timescale 1ns/100ps
module avalon_host (
  input  wire        clock,
  input  wire        avs_waitrequest,
  input  wire [31:0] avs_readdata,
  output reg  [3:0]  avs_address = 4'h0,
  output reg         avs_read = 1'b0,
  output reg         avs_write = 1'b0,
  output reg  [31:0] avs_writedata = 32'h0,
  output reg         timed_out = 1'b0
);
  // One access, held until waitrequest is seen low
  task access(input rd, input [3:0] a, input [31:0] d, output [31:0] q);
    integer n;
    begin
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      n = 0;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0 && n < 64) begin
        @(posedge clock);
        n = n + 1;
      end
      if (n == 64) timed_out = 1'b1;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
endmodule // avalon_host

/* File: test/microstep_translator_chopper_test.sv */
// Self-checking bench for the translator and chopper
// Assumes the register map of stepper_regs.vh and the host model
`timescale 1ns/100ps
`include "stepper_regs.vh"
module microstep_translator_chopper_test;
  localparam CM   = 8;
  localparam OFF  = 30 * CM;
  localparam FAST = OFF * 5 / 16;
  reg         clock = 1'b0;
  reg         resetn = 1'b0;
  wire [3:0]  avs_address;
  wire        avs_read, avs_write, avs_waitrequest;
  wire [31:0] avs_writedata, avs_readdata;
  wire [6:0]  level1, level2;
  wire        polarity1, polarity2, mixed1, mixed2;
  wire        source1, sink1, fast1, source2, sink2, fast2;
  wire [1:0]  src = {source2, source1};
  wire [1:0]  fst = {fast2, fast1};
  wire        hm = (level1 === 7'h46) && (level2 === 7'h46);
  integer     fail_count = 0;
  integer     num_checks = 0;
  integer     i, m, n;
  reg [31:0]  rd, ctl = `CTL_RESET;
  reg [1:0]   p;
  reg [6:0]   a1, a2;
  always #2.5 clock = ~clock;
  microstep_translator_chopper #(.CLOCK_MHZ(CM)) dut (
    .clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .level1(level1), .level2(level2),
    .polarity1(polarity1), .polarity2(polarity2), .mixed1(mixed1), .mixed2(mixed2),
    .source1(source1), .sink1(sink1), .fast1(fast1),
    .source2(source2), .sink2(sink2), .fast2(fast2));
  avalon_host u_host (
    .clock(clock), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .timed_out());
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      u_host.access(1'b0, a, d, rd);
    end
  endtask
  task ctl_set(input [31:0] d);
    begin
      ctl = d;
      wr(`ADDR_CONTROL, d);
      repeat (10) @(posedge clock);
    end
  endtask
  task step;
    begin
      wr(`ADDR_CONTROL, ctl | 32'h1);
      ctl_set(ctl);
    end
  endtask
  // Trip one bridge, time off phase, fast part and blanked on phase
  task chop(input b, input integer eo, input integer ef);
    integer lo, fs, hi;
    begin
      lo = 0;
      fs = 0;
      hi = 0;
      for (n = 0; n < 400 && src[b] !== 1'b1; n = n + 1) @(posedge clock);
      wr(`ADDR_CONTROL, ctl | (32'h20 << b));
      for (n = 0; n < 400 && src[b] !== 1'b0; n = n + 1) @(posedge clock);
      while (src[b] !== 1'b1 && lo < 2000) begin
        @(posedge clock);
        lo = lo + 1;
        if (fst[b] === 1'b1) fs = fs + 1;
      end
      while (src[b] === 1'b1 && hi < 400) begin
        @(posedge clock);
        hi = hi + 1;
      end
      ctl_set(ctl);
      chk(lo >= eo - 3 && lo <= eo + 3, 1);
      chk(fs >= ef - 3 && fs <= ef + 3, 1);
      chk(hi >= CM && hi <= CM + 8, 1);
    end
  endtask
  task wrap_up;
    begin
      if (u_host.timed_out !== 1'b0) fail_count = fail_count + 1;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    fail_count = fail_count + 1;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    chk({hm, polarity1, polarity2, mixed1, mixed2}, 5'h1F);
    u_host.access(1'b1, `ADDR_CONTROL, 32'h0, rd);
    chk(rd, `CTL_RESET);
    wr(4'h2, 32'hFF);
    u_host.access(1'b1, 4'h1, 32'h0, rd);
    chk(rd, 32'h0);
    u_host.access(1'b1, `ADDR_OFFTIME, 32'h0, rd);
    chk(rd, `OFFTIME_RESET);
    // Each resolution code walks one full step; switch only at home points
    for (m = 0; m < 4; m = m + 1) begin
      ctl_set({ctl[31:4], m[1:0], ctl[1:0]});
      p = {polarity1, polarity2};
      for (i = 1; i < (1 << m); i = i + 1) begin
        step;
        chk(hm, 0);
      end
      step;
      chk({hm, polarity1 ^ polarity2}, {1'b1, ~(p[1] ^ p[0])});
      if (m == 0) chk({mixed1, mixed2}, 2'b00);
    end
    ctl_set(ctl & ~32'hC);
    step;
    chk(hm, 1);
    ctl_set(ctl | 32'hC);
    step;
    chk({hm, mixed1, mixed2}, {1'b0, level1 < 7'h46, level2 < 7'h46});
    a1 = level1;
    a2 = level2;
    ctl_set(ctl ^ 32'h2);
    chk({level1, level2}, {a1, a2});
    step;
    chk({hm, mixed1, mixed2}, {1'b1, a1 > 7'h46, a2 > 7'h46});
    wr(`ADDR_OFFTIME, 32'h1);
    step;
    chk({mixed1, mixed2}, 2'b11);
    ctl_set(ctl & ~32'h10);
    step;
    chk({hm, source1, sink1, source2, sink2}, 5'h10);
    ctl_set(ctl | 32'h10);
    step;
    ctl_set(ctl | 32'h80);
    chk({hm, polarity1, polarity2}, 3'h7);
    ctl_set(ctl & ~32'h80);
    chop(1'b0, OFF, FAST);
    chop(1'b1, OFF, FAST);
    wr(`ADDR_OFFTIME, (32'd13200 << 2) | 32'h2);
    ctl_set(ctl & ~32'hC);
    step;
    chop(1'b0, 16 * CM, 0);
    wr(`ADDR_OFFTIME, 32'h0);
    chop(1'b1, OFF, 0);
    ctl_set(ctl | 32'hC);
    step;
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    chk({hm, polarity1, polarity2, mixed1, mixed2}, 5'h1F);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    wrap_up;
  end
endmodule // microstep_translator_chopper_test

/* File: test/stepper_asserts.sv */
// Checker for the translator and chopper ports
// Bound to the top module; sees only its ports
`timescale 1ns/100ps
module stepper_asserts (
  input wire       clock,
  input wire       resetn,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire [6:0] level1,
  input wire [6:0] level2,
  input wire       polarity1,
  input wire       polarity2,
  input wire       mixed1,
  input wire       mixed2,
  input wire       source1,
  input wire       sink1,
  input wire       fast1,
  input wire       source2,
  input wire       sink2,
  input wire       fast2
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_home_release: assert property ($rose(resetn) |-> level1 == 7'h46
    && level2 == 7'h46 && polarity1 && polarity2 && mixed1 && mixed2)
    else $error("levels not at home after reset");
  a_fets_reset: assert property ($rose(resetn) |-> !source1 && !sink1
    && !source2 && !sink2) else $error("bridge on during reset");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_fast_open1: assert property (fast1 |-> !source1 && !sink1)
    else $error("bridge 1 fast decay with FET on");
  a_fast_open2: assert property (fast2 |-> !source2 && !sink2)
    else $error("bridge 2 fast decay with FET on");
  a_off_hold: assert property ($fell(source1) |-> !source1 [*8])
    else $error("off interval cut short");
  a_blank_hold: assert property ($rose(source1) |-> source1 [*4])
    else $error("trip not blanked");
  a_level_range: assert property (level1 <= 7'h64 && level2 <= 7'h64)
    else $error("level above full scale");
  a_diag_pair: assert property (source1 |-> sink1)
    else $error("source on without diagonal sink");
endmodule // stepper_asserts

bind microstep_translator_chopper stepper_asserts u_asserts (
  .clock(clock), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .level1(level1), .level2(level2),
  .polarity1(polarity1), .polarity2(polarity2), .mixed1(mixed1), .mixed2(mixed2),
  .source1(source1), .sink1(sink1), .fast1(fast1),
  .source2(source2), .sink2(sink2), .fast2(fast2)
);
